// ---- design/ref_gpio_pkg.sv ----
/*
  Constants for the reference select, reference monitor and general-purpose
  pin block: register indices, field positions, reset values and codes.
  Assumes a plain register port with one-cycle read latency.
*/
package ref_gpio_pkg;

  localparam int         ADDR_W       = 4;
  localparam int         DATA_W       = 8;
  localparam int         NUM_PINS     = 4;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_REF_CFG = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_PIN_CON = 4'h2;
  localparam logic [3:0] ADDR_PIN_DIR = 4'h3;
  localparam logic [3:0] ADDR_PIN_VAL = 4'h4;

  // Reference configuration fields
  localparam int         NEG_SEL_LSB  = 0;
  localparam int         POS_SEL_LSB  = 2;
  localparam int         REF_ON_BIT   = 4;

  // Primary status field
  localparam int         ALARM_BIT    = 3;

  // Reference select codes
  localparam logic [1:0] SEL_INTERNAL = 2'h0;
  localparam logic [1:0] SEL_SUPPLY   = 2'h1;
  localparam logic [1:0] SEL_EXT_A    = 2'h2;
  localparam logic [1:0] SEL_EXT_B    = 2'h3;

  // Pins that share the second external reference pair
  localparam int         SHARED_POS   = 2;
  localparam int         SHARED_NEG   = 3;

  // Reset values
  localparam logic [1:0] SEL_RESET    = SEL_SUPPLY;
  localparam logic [3:0] PIN_CON_RST  = 4'h0;
  localparam logic [3:0] PIN_DIR_RST  = 4'hf;
  localparam logic [3:0] PIN_VAL_RST  = 4'h0;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

endpackage

// ---- design/ref_select_monitor_gpio.sv ----
/*
  Reference multiplexer selection, internal reference enable, low-reference
  alarm and four general-purpose pins behind a plain register port.
  Assumes an analog comparator gives a synchronous low-reference level and
  the converter gives a one-cycle pulse at each conversion.
*/
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ref_select_monitor_gpio
  import ref_gpio_pkg::*;
#(
  parameter int NPINS = NUM_PINS
) (
  input  wire logic                         clk,          // 20 MHz clock
  input  wire logic                         sys_rst,      // Sync reset
  input  wire logic [ref_gpio_pkg::ADDR_W-1:0] reg_addr,  // Register index
  input  wire logic [ref_gpio_pkg::DATA_W-1:0] reg_wdata, // Write data
  input  wire logic                         reg_wr,       // Write strobe
  input  wire logic                         reg_rd,       // Read strobe
  output logic [ref_gpio_pkg::DATA_W-1:0]   reg_rdata,    // Read data
  input  wire logic                         ref_low,      // Ref below limit
  input  wire logic                         conv_done,    // Conversion pulse
  output logic [1:0]                        pos_ref_select, // Pos mux code
  output logic [1:0]                        neg_ref_select, // Neg mux code
  output logic                              internal_ref_on, // Ref power
  output logic                              low_ref_alarm, // Alarm flag
  output logic                              ref_b_pins_free, // Ref B usable
  input  wire logic [NPINS-1:0]             pin_in,       // Pin levels
  output logic [NPINS-1:0]                  pin_out,      // Pin drive value
  output logic [NPINS-1:0]                  pin_oe        // Pin drive enable
);

  logic [1:0]       pos_sel_r;
  logic [1:0]       neg_sel_r;
  logic             ref_on_r;
  logic             alarm_r;
  logic [NPINS-1:0] con_r;
  logic [NPINS-1:0] dir_r;
  logic [NPINS-1:0] val_r;
  logic [NPINS-1:0] rd_val;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] rdata_r;

  // ------------------------------------------------------------------
  // Reference configuration
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pos_sel_r <= SEL_RESET;
      neg_sel_r <= SEL_RESET;
      ref_on_r  <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_REF_CFG) begin
      pos_sel_r <= reg_wdata[POS_SEL_LSB +: 2];
      neg_sel_r <= reg_wdata[NEG_SEL_LSB +: 2];
      ref_on_r  <= reg_wdata[REF_ON_BIT];
    end
  end

  // Codes go straight to the analog mux: 00 internal, 01 supply/ground,
  // 10 pair A, 11 pair B. Polarity choice is left to software.
  assign pos_ref_select  = pos_sel_r;
  assign neg_ref_select  = neg_sel_r;
  assign internal_ref_on = ref_on_r;

  // ------------------------------------------------------------------
  // Reference monitor
  // ------------------------------------------------------------------
  // Set wins: while the level is low the flag holds; it only drops at a
  // conversion with the level already good. No register write touches it.
  always_ff @(posedge clk) begin
    if (sys_rst)
      alarm_r <= 1'b0;
    else if (ref_low)
      alarm_r <= 1'b1;
    else if (conv_done)
      alarm_r <= 1'b0;
  end
  assign low_ref_alarm = alarm_r;

  // ------------------------------------------------------------------
  // General-purpose pins
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      con_r <= PIN_CON_RST;
      dir_r <= PIN_DIR_RST;
      val_r <= PIN_VAL_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_PIN_CON)
        con_r <= reg_wdata[NPINS-1:0];
      if (reg_addr == ADDR_PIN_DIR)
        dir_r <= reg_wdata[NPINS-1:0];
      if (reg_addr == ADDR_PIN_VAL)
        val_r <= reg_wdata[NPINS-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      // Detached pins stay undriven so a shared pin keeps its ref role
      assign pin_oe[g]  = con_r[g] & ~dir_r[g];
      assign pin_out[g] = val_r[g];
      // Outputs read back the written value, inputs the pin level
      assign rd_val[g]  = dir_r[g] ? pin_in[g] : val_r[g];
    end
  endgenerate

  // Pair B is usable as a reference only while both shared pins detached
  assign ref_b_pins_free = ~con_r[SHARED_POS] & ~con_r[SHARED_NEG];

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    rdata_nxt = ZERO_BYTE;
    unique case (reg_addr)
      ADDR_REF_CFG: begin
        rdata_nxt[POS_SEL_LSB +: 2] = pos_sel_r;
        rdata_nxt[NEG_SEL_LSB +: 2] = neg_sel_r;
        rdata_nxt[REF_ON_BIT]       = ref_on_r;
      end
      ADDR_STATUS:  rdata_nxt[ALARM_BIT] = alarm_r;
      ADDR_PIN_CON: rdata_nxt[NPINS-1:0] = con_r;
      ADDR_PIN_DIR: rdata_nxt[NPINS-1:0] = dir_r;
      ADDR_PIN_VAL: rdata_nxt[NPINS-1:0] = rd_val;
      default:      rdata_nxt = ZERO_BYTE;
    endcase
  end

  // Data only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst)
      rdata_r <= ZERO_BYTE;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= ZERO_BYTE;
  end
  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_low_at_conv;
    ref_low ##1 (!ref_low && conv_done);
  endsequence

  property p_ref_reset;
    @(posedge clk) sys_rst |=> pos_ref_select == SEL_SUPPLY &&
      neg_ref_select == SEL_SUPPLY && !internal_ref_on;
  endproperty
  a_ref_reset: assert property (p_ref_reset)
    else $error("reference reset state wrong");

  property p_ref_write;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_REF_CFG |=>
      pos_ref_select == $past(reg_wdata[POS_SEL_LSB +: 2]) &&
      neg_ref_select == $past(reg_wdata[NEG_SEL_LSB +: 2]);
  endproperty
  a_ref_write: assert property (p_ref_write)
    else $error("reference select not updated");

  property p_ref_on;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_REF_CFG |=>
      internal_ref_on == $past(reg_wdata[REF_ON_BIT]);
  endproperty
  a_ref_on: assert property (p_ref_on)
    else $error("reference enable not updated");

  property p_alarm_set;
    @(posedge clk) disable iff (sys_rst) ref_low |=> low_ref_alarm;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm not set on low reference");

  property p_alarm_clear;
    @(posedge clk) disable iff (sys_rst)
      s_low_at_conv |=> !low_ref_alarm;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("alarm not cleared at good conversion");

  property p_alarm_hold;
    @(posedge clk) disable iff (sys_rst)
      low_ref_alarm && !conv_done |=> low_ref_alarm;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm dropped without conversion");

  property p_alarm_read;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata[ALARM_BIT] == $past(alarm_r);
  endproperty
  a_alarm_read: assert property (p_alarm_read)
    else $error("alarm bit wrong in status read");

  property p_no_drive;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_PIN_CON && reg_wdata[NPINS-1:0] == '0
      |=> pin_oe == '0;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("detached pin still driven");

  property p_out_readback;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_PIN_VAL ##1
      (reg_rd && reg_addr == ADDR_PIN_VAL && dir_r[0] == 1'b0)
      |=> reg_rdata[0] == $past(reg_wdata[0], 2);
  endproperty
  a_out_readback: assert property (p_out_readback)
    else $error("output pin readback wrong");

  // ------------------------------------------------------------------
  // Further checks on selects, pins and the read path
  // ------------------------------------------------------------------

  sequence s_both_internal;
    reg_wr && reg_addr == ADDR_REF_CFG &&
    reg_wdata[POS_SEL_LSB +: 2] == SEL_INTERNAL &&
    reg_wdata[NEG_SEL_LSB +: 2] == SEL_INTERNAL;
  endsequence

  property p_sel_internal;
    @(posedge clk) disable iff (sys_rst)
      s_both_internal |=>
      pos_ref_select == SEL_INTERNAL && neg_ref_select == SEL_INTERNAL;
  endproperty
  a_sel_internal: assert property (p_sel_internal)
    else $error("internal reference code not applied");

  sequence s_both_supply;
    reg_wr && reg_addr == ADDR_REF_CFG &&
    reg_wdata[POS_SEL_LSB +: 2] == SEL_SUPPLY &&
    reg_wdata[NEG_SEL_LSB +: 2] == SEL_SUPPLY;
  endsequence

  property p_sel_supply;
    @(posedge clk) disable iff (sys_rst)
      s_both_supply |=>
      pos_ref_select == SEL_SUPPLY && neg_ref_select == SEL_SUPPLY;
  endproperty
  a_sel_supply: assert property (p_sel_supply)
    else $error("supply reference code not applied");

  property p_ref_hold;
    @(posedge clk) disable iff (sys_rst)
      !(reg_wr && reg_addr == ADDR_REF_CFG) |=>
      $stable(pos_ref_select) && $stable(neg_ref_select) &&
      $stable(internal_ref_on);
  endproperty
  a_ref_hold: assert property (p_ref_hold)
    else $error("reference settings changed without a write");

  property p_val_write;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_PIN_VAL |=>
      pin_out == $past(reg_wdata[NPINS-1:0]);
  endproperty
  a_val_write: assert property (p_val_write)
    else $error("pin drive value not updated");

  property p_con_write;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_PIN_CON |=>
      pin_oe == ($past(reg_wdata[NPINS-1:0]) & ~dir_r);
  endproperty
  a_con_write: assert property (p_con_write)
    else $error("pin connection not applied");

  property p_input_undriven;
    @(posedge clk) disable iff (sys_rst)
      (pin_oe & dir_r) == '0;
  endproperty
  a_input_undriven: assert property (p_input_undriven)
    else $error("input pin is driven");

  property p_dir_write;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_PIN_DIR |=>
      pin_oe == (con_r & ~$past(reg_wdata[NPINS-1:0]));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("pin direction not applied");

  property p_detached_undriven;
    @(posedge clk) disable iff (sys_rst)
      (pin_oe & ~con_r) == '0;
  endproperty
  a_detached_undriven: assert property (p_detached_undriven)
    else $error("detached pin is driven");

  property p_pin_reset;
    @(posedge clk) sys_rst |=> pin_oe == '0 && pin_out == '0;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin reset state wrong");

  property p_shared_free;
    @(posedge clk) disable iff (sys_rst)
      ref_b_pins_free |-> !pin_oe[SHARED_POS] && !pin_oe[SHARED_NEG];
  endproperty
  a_shared_free: assert property (p_shared_free)
    else $error("shared reference pin driven while free");

  property p_in_read;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_PIN_VAL |=>
      (reg_rdata[NPINS-1:0] & $past(dir_r)) ==
      ($past(pin_in) & $past(dir_r));
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input pin level wrong in value read");

  property p_status_spare;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata[DATA_W-1:ALARM_BIT+1] == '0 &&
      reg_rdata[ALARM_BIT-1:0] == '0;
  endproperty
  a_status_spare: assert property (p_status_spare)
    else $error("status read has stray bits");

  property p_status_ro;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == ADDR_STATUS && !ref_low && !conv_done |=>
      low_ref_alarm == $past(low_ref_alarm);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("status write changed the alarm");

endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
/*
  Host model: drives the plain register port with one-cycle strobes.
  Assumes the clock comes from the bench and read data lands one cycle on.
*/
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input  wire logic       clk,       // Clock
  output logic [3:0]      reg_addr,  // Register index
  output logic [7:0]      reg_wdata, // Write data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  input  wire logic [7:0] reg_rdata  // Read data
);
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released data is inverted so a stale byte never looks valid
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~dat;
    #1;
  endtask

  // Write then read with no gap, as the port allows
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] dat,
                       output logic [7:0] rdat);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk);
    reg_rd    <= 1'b0;
    reg_wdata <= ~dat;
    #1;
    rdat = reg_rdata;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] dat);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    dat = reg_rdata;
  endtask
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
/*
  Self-checking bench for the reference select and pin block.
  Assumes the host model in its own file and the design package.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  import ref_gpio_pkg::*;
  logic       clk, sys_rst, ref_low, conv_done, reg_wr, reg_rd;
  logic [3:0] reg_addr, pin_in, pin_out, pin_oe;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [1:0] pos_ref_select, neg_ref_select;
  logic       internal_ref_on, low_ref_alarm, ref_b_pins_free;
  int         n_errors = 0;
  int         checks = 0;

  ref_select_monitor_gpio dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_low(ref_low),
    .conv_done(conv_done), .pos_ref_select(pos_ref_select),
    .neg_ref_select(neg_ref_select), .internal_ref_on(internal_ref_on),
    .low_ref_alarm(low_ref_alarm), .ref_b_pins_free(ref_b_pins_free),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ----------------------------------------------------------------
  // Checks and verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic t_reset;
    chk({4'h0, pos_ref_select, neg_ref_select}, 8'h05);
    chk({7'h0, internal_ref_on}, 8'h00);
    chk({4'h0, pin_oe}, 8'h00);
    host.rd(ADDR_REF_CFG, d);
    chk(d, 8'h05);
  endtask

  // Each of the four codes on both sides, with the internal reference on
  task automatic t_select;
    for (int c = 0; c < 4; c++) begin
      host.wr(ADDR_REF_CFG, 8'h10 | 8'(c * 5));
      chk({4'h0, pos_ref_select, neg_ref_select}, 8'(c * 5));
      chk({7'h0, internal_ref_on}, 8'h01);
    end
    host.wr(ADDR_REF_CFG, 8'h05);
    chk({7'h0, internal_ref_on}, 8'h00);
    host.wr(ADDR_STATUS, 8'hff);
    host.rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    host.rd(4'hf, d);
    chk(d, 8'h00);
  endtask

  task automatic t_alarm;
    @(posedge clk);
    ref_low <= 1'b1;
    @(posedge clk);
    #1;
    chk({7'h0, low_ref_alarm}, 8'h01);
    @(posedge clk);
    ref_low <= 1'b0;
    host.rd(ADDR_STATUS, d);
    chk(d, 8'h08);
    host.rd(ADDR_STATUS, d);
    chk(d, 8'h08);
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    #1;
    chk({7'h0, low_ref_alarm}, 8'h00);
    // Conversion right after the level recovers clears the flag
    @(posedge clk);
    ref_low <= 1'b1;
    @(posedge clk);
    ref_low   <= 1'b0;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    #1;
    chk({7'h0, low_ref_alarm}, 8'h00);
    // Low level and conversion together: set wins
    @(posedge clk);
    ref_low   <= 1'b1;
    conv_done <= 1'b1;
    @(posedge clk);
    ref_low   <= 1'b0;
    conv_done <= 1'b0;
    #1;
    chk({7'h0, low_ref_alarm}, 8'h01);
  endtask

  task automatic t_pins;
    @(posedge clk);
    pin_in <= 4'h5;
    host.wr(ADDR_PIN_CON, 8'h0f);
    host.wr(ADDR_PIN_DIR, 8'h03);
    host.wr(ADDR_PIN_VAL, 8'h0a);
    chk({pin_oe, pin_out}, 8'hca);
    chk({7'h0, ref_b_pins_free}, 8'h00);
    host.rd(ADDR_PIN_VAL, d);
    chk(d, 8'h09);
    host.wr(ADDR_PIN_CON, 8'h03);
    chk({pin_oe, 3'h0, ref_b_pins_free}, 8'h01);
  endtask

  task automatic t_outs;
    host.wr(ADDR_PIN_DIR, 8'h00);
    host.wr_rd(ADDR_PIN_VAL, 8'h06, d);
    chk(d, 8'h06);
    chk({pin_oe, pin_out}, 8'h36);
  endtask

  task automatic t_rerun;
    host.wr(ADDR_REF_CFG, 8'h1a);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({4'h0, pos_ref_select, neg_ref_select}, 8'h05);
    chk({6'h0, internal_ref_on, low_ref_alarm}, 8'h00);
    chk({pin_oe, pin_out}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    sys_rst   = 1'b1;
    ref_low   = 1'b0;
    conv_done = 1'b0;
    pin_in    = 4'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_select();
    t_alarm();
    t_pins();
    t_outs();
    t_rerun();
    results();
  end

  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule

`default_nettype wire
